// ===== hdl/smsc_mode_switch.sv
`timescale 1ns/1ps
`default_nettype none
module smsc_mode_switch (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Object access from the fieldbus side
  input wire smsc_pkg::smsc_req_t i_req,
  output var smsc_pkg::smsc_rsp_t o_rsp,
  // Synchronization cycle in microseconds
  input wire logic [15:0] i_sync_cycle_us,
  // Drive status
  input wire logic i_homing_running,
  input wire logic i_homing_done,
  input wire logic i_fault,
  input wire logic i_enabled,
  input wire logic i_ramp_done,
  // Drive commands
  output logic o_discard_pos,
  output logic o_ramp_stop,
  output logic [7:0] o_active_mode,
  output logic o_cycle_ok,
  output logic o_switch_refused
);
  import smsc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_valid_mode(input logic [7:0] m);
    is_valid_mode = (m == SMSC_MODE_PP) || (m == SMSC_MODE_PV) || (m == SMSC_MODE_PT) ||
                    (m == SMSC_MODE_HM) || (m == SMSC_MODE_IP) || (m == SMSC_MODE_CSP) ||
                    (m == SMSC_MODE_CSV) || (m == SMSC_MODE_CST);
  endfunction

  // The pp and csp position modes hold queued commands that must not outlive the mode
  function automatic logic leaves_queue(input logic [7:0] m);
    leaves_queue = (m == SMSC_MODE_PP) || (m == SMSC_MODE_CSP);
  endfunction

  // Velocity and torque modes must come to rest before handing over
  function automatic logic needs_ramp(input logic [7:0] m);
    needs_ramp = (m == SMSC_MODE_PV) || (m == SMSC_MODE_PT) || (m == SMSC_MODE_CSV) ||
                 (m == SMSC_MODE_CST);
  endfunction

  function automatic logic cycle_supported(input logic [7:0] m, input logic [15:0] c);
    logic small_ok;
    logic big_ok;
    small_ok = (c == SMSC_CYC_200US) || (c == SMSC_CYC_400US) || (c == SMSC_CYC_1MS);
    big_ok = (c > SMSC_CYC_1MS) && (c <= SMSC_CYC_MAX_US) &&
             ((c % SMSC_POS_LOOP_US) == 16'h0000);
    if (c == SMSC_CYC_100US) begin
      cycle_supported = 1'b0;
    end else if (m == SMSC_MODE_PT) begin
      cycle_supported = 1'b0;
    end else begin
      cycle_supported = small_ok || big_ok;
    end
  endfunction

  smsc_state_t state_ff;
  smsc_state_t nxt_state;
  logic [7:0] sel_ff;
  logic [7:0] active_ff;
  logic [7:0] target_ff;
  logic [7:0] nxt_target;
  logic discard_ff;
  logic ramp_ff;
  logic refused_ff;
  logic cycle_ok_ff;
  logic ack_ff;
  logic err_ff;
  logic [15:0] rdata_ff;
  logic homing_locked;
  logic want_switch;
  logic any_req;
  logic sel_wr;
  logic sel_rd;
  logic disp_rd;

  // Homing holds its mode until it finishes or is broken off
  assign homing_locked = (active_ff == SMSC_MODE_HM) && i_homing_running &&
                         !i_homing_done && !i_fault && i_enabled;
  assign want_switch = (sel_ff != active_ff) && is_valid_mode(sel_ff);

  // Strobe decode shared by the object store and the response
  assign any_req = i_req.wr || i_req.rd;
  assign sel_wr = i_req.wr && (i_req.addr == SMSC_ADDR_MODE_SEL);
  assign sel_rd = i_req.rd && (i_req.addr == SMSC_ADDR_MODE_SEL);
  assign disp_rd = i_req.rd && (i_req.addr == SMSC_ADDR_MODE_DISP);

  // ----------------------------------------
  // Mode selection object
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sel_ff <= SMSC_MODE_RESET;
    end else if (sel_wr) begin
      sel_ff <= i_req.wdata[7:0];
    end
  end

  // Every access is answered one cycle later, so a master never waits
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= any_req;
    end
  end

  // Display is read only, other addresses are not mapped
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= any_req && !sel_wr && !sel_rd && !disp_rd;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= 16'h0000;
    end else if (disp_rd) begin
      rdata_ff <= {8'h00, active_ff};
    end else if (sel_rd) begin
      rdata_ff <= {8'h00, sel_ff};
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Switch sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_target = target_ff;
    case (state_ff)
      SMSC_ST_IDLE: begin
        if (want_switch && !homing_locked) begin
          nxt_target = sel_ff;
          // A selection written mid-switch waits until the sequencer is idle again
          if (leaves_queue(active_ff)) begin
            nxt_state = SMSC_ST_DISCARD;
          end else if (needs_ramp(active_ff)) begin
            nxt_state = SMSC_ST_RAMP;
          end else begin
            nxt_state = SMSC_ST_COMMIT;
          end
        end
      end
      SMSC_ST_DISCARD: nxt_state = SMSC_ST_COMMIT;
      SMSC_ST_RAMP: begin
        if (i_ramp_done) begin
          nxt_state = SMSC_ST_COMMIT;
        end
      end
      SMSC_ST_COMMIT: nxt_state = SMSC_ST_IDLE;
      default: nxt_state = SMSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= SMSC_ST_IDLE;
      target_ff <= SMSC_MODE_RESET;
    end else begin
      state_ff <= nxt_state;
      target_ff <= nxt_target;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      active_ff <= SMSC_MODE_RESET;
    end else if (state_ff == SMSC_ST_COMMIT) begin
      active_ff <= target_ff;
    end
  end

  // ----------------------------------------
  // Drive command outputs
  // ----------------------------------------
  // Commands look ahead at the next state so they line up with it
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      discard_ff <= 1'b0;
    end else begin
      discard_ff <= (nxt_state == SMSC_ST_DISCARD);
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ramp_ff <= 1'b0;
    end else begin
      ramp_ff <= (nxt_state == SMSC_ST_RAMP);
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= (state_ff == SMSC_ST_IDLE) && want_switch && homing_locked;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cycle_ok_ff <= 1'b0;
    end else begin
      cycle_ok_ff <= cycle_supported(active_ff, i_sync_cycle_us);
    end
  end

  assign o_rsp = '{ack: ack_ff, err: err_ff, rdata: rdata_ff};
  assign o_active_mode = active_ff;
  assign o_discard_pos = discard_ff;
  assign o_ramp_stop = ramp_ff;
  assign o_switch_refused = refused_ff;
  assign o_cycle_ok = cycle_ok_ff;
endmodule // smsc_mode_switch
`default_nettype wire

// ===== hdl/smsc_pkg.sv
// Behaviour
// - The mode display holds the active mode code 0 to 10, with 1 pp, 3 pv, 4 pt, 6 hm, 7 ip, 8 csp, 9 csv and 10 cst, and 0, 2 and 5 reserved.
// - Leaving pp or csp for another mode discards every position command not yet executed.
// - Leaving pv, pt, csv or cst first runs a ramp stop, and the new mode is entered only after it completes.
// - While homing is active and running, a request for another mode is refused.
// - A switch out of homing is allowed once homing has completed or was interrupted by a fault or loss of enable.
// - A synchronization cycle of 100 us is unsupported in every mode.
// - Cycles of 200 us, 400 us and 1 ms are accepted in pp, hm, pv and the cyclic synchronous modes, but never in pt.
// - Cycles above 1 ms are supported only as integer multiples of 200 us up to 8 ms.
// - The requested mode comes from a separate read-write selection object, and the display reports the mode in force.
package smsc_pkg;
  // ----------------------------------------
  // Object addresses and reset values
  // ----------------------------------------
  localparam logic [15:0] SMSC_ADDR_MODE_SEL = 16'h6060;
  localparam logic [15:0] SMSC_ADDR_MODE_DISP = 16'h6061;
  localparam logic [7:0] SMSC_MODE_RESET = 8'h00;

  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [7:0] SMSC_MODE_NONE = 8'h00;
  localparam logic [7:0] SMSC_MODE_PP = 8'h01;
  localparam logic [7:0] SMSC_MODE_PV = 8'h03;
  localparam logic [7:0] SMSC_MODE_PT = 8'h04;
  localparam logic [7:0] SMSC_MODE_HM = 8'h06;
  localparam logic [7:0] SMSC_MODE_IP = 8'h07;
  localparam logic [7:0] SMSC_MODE_CSP = 8'h08;
  localparam logic [7:0] SMSC_MODE_CSV = 8'h09;
  localparam logic [7:0] SMSC_MODE_CST = 8'h0a;

  // ----------------------------------------
  // Cycle times in microseconds
  // ----------------------------------------
  localparam logic [15:0] SMSC_CYC_100US = 16'h0064;
  localparam logic [15:0] SMSC_CYC_200US = 16'h00c8;
  localparam logic [15:0] SMSC_CYC_400US = 16'h0190;
  localparam logic [15:0] SMSC_CYC_1MS = 16'h03e8;
  localparam logic [15:0] SMSC_CYC_MAX_US = 16'h1f40;
  localparam logic [15:0] SMSC_POS_LOOP_US = 16'h00c8;

  // ----------------------------------------
  // Object bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } smsc_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } smsc_rsp_t;

  typedef enum logic [2:0] {
    SMSC_ST_IDLE,
    SMSC_ST_DISCARD,
    SMSC_ST_RAMP,
    SMSC_ST_COMMIT
  } smsc_state_t;
endpackage

// ===== test/smsc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module smsc_ctrl_model
  import smsc_pkg::*;
#(
  parameter int unsigned CMD_GAP = 100
) (
  // Clock
  input wire logic i_mclk,
  // Object bus
  output var smsc_req_t o_req,
  input wire smsc_rsp_t i_rsp
);
  // ---------------
  // Controller side
  // ---------------
  logic [15:0] rdata;
  logic err;
  initial o_req = '0;
  // Released lines show the inverse so a stale value never passes
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_mclk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    rdata = i_rsp.rdata;
    err = !i_rsp.ack || i_rsp.err;
    // An idle edge between transfers so a strobe is never re-raised in one step
    @(posedge i_mclk);
    #1;
    // Gap shortened from 1 ms to keep the run brief
    if (w && d[7:0] inside {SMSC_MODE_CSP, SMSC_MODE_CSV, SMSC_MODE_CST})
      #(CMD_GAP * 10);
  endtask
endmodule // smsc_ctrl_model
`default_nettype wire

// ===== test/smsc_mode_switch_props.sv
`timescale 1ns/1ps
`default_nettype none
module smsc_mode_switch_props
  import smsc_pkg::*;
(
  // Inputs of the block
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire smsc_req_t i_req,
  input wire logic [15:0] i_sync_cycle_us,
  input wire logic i_homing_running,
  input wire logic i_homing_done,
  input wire logic i_fault,
  input wire logic i_enabled,
  input wire logic i_ramp_done,
  // Outputs of the block
  input wire smsc_rsp_t o_rsp,
  input wire logic o_discard_pos,
  input wire logic o_ramp_stop,
  input wire logic [7:0] o_active_mode,
  input wire logic o_cycle_ok,
  input wire logic o_switch_refused
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_ACK: assert property (o_rsp.ack == $past(i_req.wr || i_req.rd))
    else $error("ack timing");
  AST_DISP_RO: assert property (i_req.wr && i_req.addr == SMSC_ADDR_MODE_DISP |=> o_rsp.err)
    else $error("display write accepted");
  AST_RANGE: assert property (o_active_mode inside {0, 1, 3, 4, 6, 7, 8, 9, 10})
    else $error("bad mode code");
  AST_DISCARD: assert property ($rose(o_discard_pos) |-> o_active_mode inside {1, 8})
    else $error("discard from wrong mode");
  AST_RAMP: assert property ($rose(o_ramp_stop) |-> o_active_mode inside {3, 4, 9, 10})
    else $error("ramp from wrong mode");
  AST_RAMP_HOLD: assert property (o_ramp_stop && !i_ramp_done |=> $stable(o_active_mode))
    else $error("mode left before stop");
  AST_HOME_LOCK: assert property (o_active_mode == 6 && i_homing_running
    && !i_homing_done && !i_fault && i_enabled |=> o_active_mode == 6)
    else $error("homing left while running");
  AST_REFUSE_HM: assert property (o_switch_refused |-> o_active_mode == 6)
    else $error("switch refused outside homing");
  AST_PT_CYCLE: assert property ((o_active_mode == 4) [*2] |-> !o_cycle_ok)
    else $error("torque cycle accepted");
  AST_CYC_100: assert property ((i_sync_cycle_us == 16'h0064) [*2] |-> !o_cycle_ok)
    else $error("100 us accepted");
endmodule // smsc_mode_switch_props
bind smsc_mode_switch smsc_mode_switch_props u_props (.i_mclk, .i_reset, .i_req,
  .i_sync_cycle_us, .i_homing_running, .i_homing_done, .i_fault, .i_enabled, .i_ramp_done,
  .o_rsp, .o_discard_pos, .o_ramp_stop, .o_active_mode, .o_cycle_ok, .o_switch_refused);
`default_nettype wire

// ===== test/test_servo_mode_switch_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_servo_mode_switch_control;
  import smsc_pkg::*;
  // -----------
  // Environment
  // -----------
  logic i_mclk = 0, i_reset = 1, hm_run = 0, hm_done = 0, fault = 0, enbl = 1, rmp_done = 0;
  logic disc, ramp, ok, refused, seen_disc;
  logic [15:0] cyc = 16'h03e8;
  logic [15:0] cyc_tab [8] = '{16'h0064, 16'h00c8, 16'h0190, 16'h03e8, 16'h04b0, 16'h1f40,
    16'h2008, 16'h044c};
  logic [7:0] mode, ok_tab = 8'h3e;
  smsc_req_t req;
  smsc_rsp_t rsp;
  int mismatches = 0, n_checks = 0;
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (disc) seen_disc = 1'b1;
  smsc_mode_switch u_dut (.i_mclk, .i_reset, .i_req(req), .o_rsp(rsp), .i_sync_cycle_us(cyc),
    .i_homing_running(hm_run), .i_homing_done(hm_done), .i_fault(fault), .i_enabled(enbl),
    .i_ramp_done(rmp_done), .o_discard_pos(disc), .o_ramp_stop(ramp), .o_active_mode(mode),
    .o_cycle_ok(ok), .o_switch_refused(refused));
  smsc_ctrl_model u_ctl (.i_mclk, .o_req(req), .i_rsp(rsp));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_mode(input logic [7:0] m);
    for (int n = 0; mode !== m; n++) begin
      if (n == 60) begin `CHK(mode, m) stop_test(); end
      step(1);
    end
  endtask
  task automatic sel(input logic [7:0] m);
    u_ctl.access(1'b1, SMSC_ADDR_MODE_SEL, {8'h00, m});
    `CHK(u_ctl.err, 1'b0)
  endtask
  task automatic t_regs();
    u_ctl.access(1'b0, SMSC_ADDR_MODE_DISP, 16'h0000);
    `CHK(u_ctl.rdata, 16'h0000)
    u_ctl.access(1'b1, SMSC_ADDR_MODE_DISP, 16'h0003);
    `CHK(u_ctl.err, 1'b1)
    u_ctl.access(1'b0, 16'h6062, 16'h0000);
    `CHK(u_ctl.err, 1'b1)
    sel(SMSC_MODE_PV);
    `CHK(mode, SMSC_MODE_NONE)
    wait_mode(SMSC_MODE_PV);
    u_ctl.access(1'b0, SMSC_ADDR_MODE_SEL, 16'h0000);
    `CHK(u_ctl.rdata, 16'h0003)
  endtask
  task automatic t_ramp();
    sel(SMSC_MODE_PP);
    step(6);
    `CHK({ramp, mode}, {1'b1, SMSC_MODE_PV})
    rmp_done = 1'b1;
    wait_mode(SMSC_MODE_PP);
    rmp_done = 1'b0;
    `CHK(ramp, 1'b0)
    sel(8'h05);
    step(4);
    `CHK(mode, SMSC_MODE_PP)
  endtask
  task automatic t_discard();
    seen_disc = 1'b0;
    sel(SMSC_MODE_CSP);
    wait_mode(SMSC_MODE_CSP);
    `CHK(seen_disc, 1'b1)
    for (int i = 0; i < 8; i++) begin
      cyc = cyc_tab[i];
      step(3);
      `CHK(ok, ok_tab[i])
    end
  endtask
  task automatic t_home();
    cyc = SMSC_CYC_200US;
    sel(SMSC_MODE_PT);
    wait_mode(SMSC_MODE_PT);
    step(2);
    `CHK(ok, 1'b0)
    rmp_done = 1'b1;
    sel(SMSC_MODE_HM);
    wait_mode(SMSC_MODE_HM);
    hm_run = 1'b1;
    sel(SMSC_MODE_PV);
    step(5);
    `CHK({refused, mode}, {1'b1, SMSC_MODE_HM})
    fault = 1'b1;
    wait_mode(SMSC_MODE_PV);
    `CHK(refused, 1'b0)
  endtask
  initial begin
    step(12);
    i_reset = 1'b0;
    t_regs();
    t_ramp();
    t_discard();
    t_home();
    stop_test();
  end
endmodule // test_servo_mode_switch_control
`default_nettype wire
